// *** inc/lpd_pkg.sv ***
package lpd_pkg;

  // ==========================================================
  // APB register map (byte addresses)
  localparam logic [7:0]  ADDR_CMD        = 8'h00;
  localparam logic [7:0]  ADDR_DATA       = 8'h04;
  localparam logic [7:0]  ADDR_CTRL       = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
  localparam logic [7:0]  ADDR_DUTY       = 8'h10;
  localparam logic [7:0]  ADDR_BLOCKS     = 8'h14;
  localparam logic [7:0]  ADDR_DRIVE      = 8'h18;

  // ==========================================================
  // Field positions
  localparam int          CTRL_SERIAL_BIT = 0;
  localparam int          ST_DISP_ON_BIT  = 0;
  localparam int          ST_INVERSE_BIT  = 1;
  localparam int          ST_ALL_ON_BIT   = 2;
  localparam int          ST_PSAVE_BIT    = 3;
  localparam int          ST_SUB_BIT      = 4;
  localparam int          ST_FULL_BIT     = 5;

  // ==========================================================
  // Main table opcodes
  localparam logic [6:0]  OP_DISP_ONOFF   = 7'h57;
  localparam logic [6:0]  OP_INVERSE      = 7'h53;
  localparam logic [6:0]  OP_STATIC       = 7'h52;
  localparam logic [7:0]  OP_SUB_ENTER    = 8'h70;
  localparam logic [3:0]  OP_COL_HI       = 4'h1;
  localparam logic [3:0]  OP_COL_LO       = 4'h0;
  localparam logic [3:0]  OP_PAGE_HI      = 4'h4;
  localparam logic [3:0]  OP_PAGE_LO      = 4'hC;

  // ==========================================================
  // Sub table opcodes
  localparam logic [3:0]  SUB_S1          = 4'h0;
  localparam logic [3:0]  SUB_C1          = 4'h1;
  localparam logic [3:0]  SUB_S2          = 4'h2;
  localparam logic [3:0]  SUB_C2          = 4'h3;
  localparam logic [7:0]  SUB_EXEC        = 8'h40;
  localparam logic [3:0]  SUB_NL_HI       = 4'h5;
  localparam logic [3:0]  SUB_NL_LO       = 4'h6;
  localparam logic [7:0]  SUB_NL_EXEC     = 8'h70;
  localparam logic [3:0]  SUB_EVR_HI      = 4'h8;
  localparam logic [3:0]  SUB_EVR_LO      = 4'h9;
  localparam logic [7:0]  SUB_EVR_EXEC    = 8'hA0;
  localparam logic [7:0]  OP_SUB_END      = 8'h71;

  // ==========================================================
  // Geometry and reset values
  localparam logic [3:0]  NUM_UNITS       = 4'hB;
  localparam logic [6:0]  COMS_PER_UNIT   = 7'h08;
  localparam logic [7:0]  NUM_COLS        = 8'h84;
  localparam logic [4:0]  NUM_PAGES       = 5'h0F;
  localparam int          MEM_DEPTH       = 1980;
  localparam logic [6:0]  DUTY_RESET      = 7'h58;
  localparam logic [7:0]  EVR_RESET       = 8'hFF;

  typedef enum logic {TBL_MAIN, TBL_SUB} lpd_table_t;

endpackage

// *** inc/lpd_core_if.sv ***
interface lpd_core_if;
  logic        mem_we;
  logic [10:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [3:0]  s1;
  logic [3:0]  c1;
  logic [3:0]  s2;
  logic [3:0]  c2;
  logic        full;
  logic [6:0]  duty;
  logic [3:0]  blk2_off;

  modport mem  (input mem_we, mem_addr, mem_wdata, output mem_rdata);
  modport calc (input s1, c1, s2, c2, output full, duty, blk2_off);
  modport ctrl (output mem_we, mem_addr, mem_wdata, s1, c1, s2, c2,
                input mem_rdata, full, duty, blk2_off);
endinterface

// *** rtl/lpd_display_mem.sv ***
module lpd_display_mem
  import lpd_pkg::*;
(
  input wire logic pclk,
  lpd_core_if.mem  core
);

  // ==========================================================
  // Display memory array
  logic [7:0] mem_array [0:MEM_DEPTH-1];

  // Write port, contents never touched by display modes
  always_ff @(posedge pclk)
  begin
    if (core.mem_we)
      mem_array[core.mem_addr] <= core.mem_wdata;
  end

  // Asynchronous read port
  assign core.mem_rdata = mem_array[core.mem_addr];

endmodule

// *** rtl/lpd_partial_calc.sv ***
module lpd_partial_calc
  import lpd_pkg::*;
(
  lpd_core_if.calc core
);

  // ==========================================================
  // Duty from block settings
  wire logic       full_hit;
  wire logic [3:0] units;

  // Whole panel overrides the second block
  assign full_hit      = (core.s1 == 4'h0) && (core.c1 == NUM_UNITS);
  assign units         = full_hit ? NUM_UNITS : 4'(core.c1 + core.c2);
  assign core.full     = full_hit;
  assign core.duty     = 7'(units * COMS_PER_UNIT);
  // Second block data follows the first in memory, shown adjacent
  assign core.blk2_off = full_hit ? 4'h0 : core.c1;

endmodule

// *** rtl/lpd_top.sv ***
// How it works
// - A data read returns the display memory byte latched at page and column by the previous data read.
// - Each display data read advances the column address by one, up to the last column plus one.
// - Display data reads are refused while serial interface mode is selected.
// - Inverse command flips whole panel polarity; memory untouched.
// - Static drive bit 0 forces all pixels on; memory preserved.
// - All pixels on overrides the inverse setting.
// - Static drive on while display off enters power save.
// - Enter command switches decoding to the sub instruction table.
// - Panel is eleven units of eight commons, eighty-eight commons total.
// - Two blocks of start and count; duty follows total units.
// - Start zero count eleven gives full panel and ignores block two.
// - Sub upper nibble selects block field, lower nibble is the value.
// - Execute command applies block settings and changes duty.
// - Blocks shown adjacent; second block data follows first in memory.
// - Partial execute changes duty only, not bias or drive form.
// - End sub mode command returns decoding to the main table.
module lpd_top
  import lpd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             display_on,
  output logic             pix_invert,
  output logic             pix_all_on,
  output logic             power_save,
  output logic             sub_table,
  output logic [6:0]       duty_ratio,
  output logic [3:0]       blk1_start,
  output logic [3:0]       blk1_count,
  output logic [3:0]       blk2_start,
  output logic [3:0]       blk2_count,
  output logic [3:0]       blk2_mem_offset,
  output logic [5:0]       nline_count,
  output logic [7:0]       evr_level
);

  // ==========================================================
  // Decode helpers
  function automatic logic nib_hit(input logic [7:0] b, input logic [3:0] n);
    nib_hit = (b[7:4] == n);
  endfunction

  // ==========================================================
  // State
  lpd_table_t  table_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        serial_reg;
  logic        disp_on_reg;
  logic        inverse_reg;
  logic        all_on_reg;
  logic        psave_reg;
  logic        pix_inv_reg;
  logic        pix_on_reg;
  logic [4:0]  page_reg;
  logic [7:0]  col_reg;
  logic [7:0]  rd_latch_reg;
  logic [3:0]  s1_reg;
  logic [3:0]  c1_reg;
  logic [3:0]  s2_reg;
  logic [3:0]  c2_reg;
  logic [3:0]  a_s1_reg;
  logic [3:0]  a_c1_reg;
  logic [3:0]  a_s2_reg;
  logic [3:0]  a_c2_reg;
  logic        full_reg;
  logic [6:0]  duty_reg;
  logic [3:0]  blk2_off_reg;
  logic [5:0]  nl_pend_reg;
  logic [5:0]  nl_reg;
  logic [7:0]  evr_pend_reg;
  logic [7:0]  evr_reg;

  lpd_core_if core ();

  // ==========================================================
  // APB access decode
  wire logic       take;
  wire logic       addr_ok;
  wire logic       wr_cmd;
  wire logic       wr_data;
  wire logic       rd_req;
  wire logic       rd_data;
  wire logic       rd_refused;
  wire logic       wr_ctrl;
  wire logic [7:0] cmd;
  wire logic       in_main;
  wire logic       in_sub;

  assign take       = psel & penable & ~pready_reg;
  assign addr_ok    = (paddr == ADDR_CMD) || (paddr == ADDR_DATA) || (paddr == ADDR_CTRL)
                   || (paddr == ADDR_STATUS) || (paddr == ADDR_DUTY)
                   || (paddr == ADDR_BLOCKS) || (paddr == ADDR_DRIVE);
  assign cmd        = pwdata[7:0];
  assign wr_cmd     = take & pwrite & (paddr == ADDR_CMD);
  assign wr_data    = take & pwrite & (paddr == ADDR_DATA);
  assign wr_ctrl    = take & pwrite & (paddr == ADDR_CTRL);
  assign rd_req     = take & ~pwrite & (paddr == ADDR_DATA);
  assign rd_data    = rd_req & ~serial_reg;
  assign rd_refused = rd_req & serial_reg;
  assign in_main    = (table_reg == TBL_MAIN);
  assign in_sub     = (table_reg == TBL_SUB);

  // ==========================================================
  // Main table commands
  wire logic m_disp;
  wire logic m_inv;
  wire logic m_static;
  wire logic m_sub_in;
  wire logic m_col_hi;
  wire logic m_col_lo;
  wire logic m_page_hi;
  wire logic m_page_lo;

  assign m_disp    = wr_cmd & in_main & (cmd[7:1] == OP_DISP_ONOFF);
  assign m_inv     = wr_cmd & in_main & (cmd[7:1] == OP_INVERSE);
  assign m_static  = wr_cmd & in_main & (cmd[7:1] == OP_STATIC);
  assign m_sub_in  = wr_cmd & in_main & (cmd == OP_SUB_ENTER);
  assign m_col_hi  = wr_cmd & in_main & nib_hit(cmd, OP_COL_HI);
  assign m_col_lo  = wr_cmd & in_main & nib_hit(cmd, OP_COL_LO);
  assign m_page_hi = wr_cmd & in_main & nib_hit(cmd, OP_PAGE_HI);
  assign m_page_lo = wr_cmd & in_main & nib_hit(cmd, OP_PAGE_LO);

  // ==========================================================
  // Sub table commands
  wire logic s_s1;
  wire logic s_c1;
  wire logic s_s2;
  wire logic s_c2;
  wire logic s_exec;
  wire logic s_nl_hi;
  wire logic s_nl_lo;
  wire logic s_nl_exec;
  wire logic s_evr_hi;
  wire logic s_evr_lo;
  wire logic s_evr_exec;
  wire logic s_end;

  assign s_s1       = wr_cmd & in_sub & nib_hit(cmd, SUB_S1);
  assign s_c1       = wr_cmd & in_sub & nib_hit(cmd, SUB_C1);
  assign s_s2       = wr_cmd & in_sub & nib_hit(cmd, SUB_S2);
  assign s_c2       = wr_cmd & in_sub & nib_hit(cmd, SUB_C2);
  assign s_exec     = wr_cmd & in_sub & (cmd == SUB_EXEC);
  assign s_nl_hi    = wr_cmd & in_sub & nib_hit(cmd, SUB_NL_HI);
  assign s_nl_lo    = wr_cmd & in_sub & nib_hit(cmd, SUB_NL_LO);
  assign s_nl_exec  = wr_cmd & in_sub & (cmd == SUB_NL_EXEC);
  assign s_evr_hi   = wr_cmd & in_sub & nib_hit(cmd, SUB_EVR_HI);
  assign s_evr_lo   = wr_cmd & in_sub & nib_hit(cmd, SUB_EVR_LO);
  assign s_evr_exec = wr_cmd & in_sub & (cmd == SUB_EVR_EXEC);
  assign s_end      = wr_cmd & in_sub & (cmd == OP_SUB_END);

  // ==========================================================
  // Display mode next values
  wire logic disp_on_next;
  wire logic inverse_next;
  wire logic all_on_next;
  wire logic psave_next;

  assign disp_on_next = m_disp ? cmd[0] : disp_on_reg;
  assign inverse_next = m_inv ? cmd[0] : inverse_reg;
  assign all_on_next  = m_static ? cmd[0] : all_on_reg;
  assign psave_next   = all_on_next & ~disp_on_next;

  // ==========================================================
  // Memory addressing, column stops at last column plus one
  wire logic       col_in_range;
  wire logic       col_inc;
  wire logic [7:0] col_next;
  wire logic [4:0] page_next;

  assign col_in_range   = (col_reg < NUM_COLS) && (page_reg < NUM_PAGES);
  assign col_inc        = (wr_data | rd_data) & (col_reg < NUM_COLS);
  assign col_next       = m_col_hi ? {cmd[3:0], col_reg[3:0]} :
                          m_col_lo ? {col_reg[7:4], cmd[3:0]} :
                          col_inc  ? 8'(col_reg + 8'h01) : col_reg;
  assign page_next      = m_page_hi ? {cmd[0], page_reg[3:0]} :
                          m_page_lo ? {page_reg[4], cmd[3:0]} : page_reg;
  assign core.mem_addr  = 11'(11'(page_reg) * 11'(NUM_COLS) + 11'(col_reg));
  assign core.mem_we    = wr_data & col_in_range;
  assign core.mem_wdata = cmd;
  assign core.s1        = s1_reg;
  assign core.c1        = c1_reg;
  assign core.s2        = s2_reg;
  assign core.c2        = c2_reg;

  // ==========================================================
  // Read data selection
  logic [31:0] rdata_next;

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      ADDR_DATA:   rdata_next = {24'h00_0000, rd_latch_reg};
      ADDR_CTRL:   rdata_next = {31'h0000_0000, serial_reg};
      ADDR_STATUS: rdata_next = {26'h000_0000, full_reg, in_sub, psave_reg,
                                 all_on_reg, inverse_reg, disp_on_reg};
      ADDR_DUTY:   rdata_next = {25'h000_0000, duty_reg};
      ADDR_BLOCKS: rdata_next = {16'h0000, a_c2_reg, a_s2_reg, a_c1_reg, a_s1_reg};
      ADDR_DRIVE:  rdata_next = {18'h0_0000, nl_reg, evr_reg};
      default:     rdata_next = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // APB handshake, answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= take;
      pslverr_reg <= take & (~addr_ok | rd_refused);
      prdata_reg  <= (take & ~pwrite & ~rd_refused) ? rdata_next : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Table selection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      table_reg <= TBL_MAIN;
    else
    begin
      case (table_reg)
        TBL_MAIN: if (m_sub_in) table_reg <= TBL_SUB;
        TBL_SUB:  if (s_end) table_reg <= TBL_MAIN;
        default:  table_reg <= TBL_MAIN;
      endcase
    end
  end

  // ==========================================================
  // Display modes and polarity drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_reg  <= 1'b0;
      disp_on_reg <= 1'b0;
      inverse_reg <= 1'b0;
      all_on_reg  <= 1'b0;
      psave_reg   <= 1'b0;
      pix_inv_reg <= 1'b0;
      pix_on_reg  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        serial_reg <= pwdata[CTRL_SERIAL_BIT];
      disp_on_reg <= disp_on_next;
      inverse_reg <= inverse_next;
      all_on_reg  <= all_on_next;
      psave_reg   <= psave_next;
      pix_on_reg  <= all_on_next;
      pix_inv_reg <= inverse_next & ~all_on_next;
    end
  end

  // ==========================================================
  // Address counters and read latch, first read after a move is stale
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_reg     <= 5'h00;
      col_reg      <= 8'h00;
      rd_latch_reg <= 8'h00;
    end
    else
    begin
      page_reg <= page_next;
      col_reg  <= col_next;
      if (rd_data)
        rd_latch_reg <= col_in_range ? core.mem_rdata : 8'h00;
    end
  end

  // ==========================================================
  // Partial display settings, applied on execute only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg       <= 4'h0;
      c1_reg       <= NUM_UNITS;
      s2_reg       <= 4'h0;
      c2_reg       <= 4'h0;
      a_s1_reg     <= 4'h0;
      a_c1_reg     <= NUM_UNITS;
      a_s2_reg     <= 4'h0;
      a_c2_reg     <= 4'h0;
      full_reg     <= 1'b1;
      duty_reg     <= DUTY_RESET;
      blk2_off_reg <= 4'h0;
    end
    else
    begin
      if (s_s1) s1_reg <= cmd[3:0];
      if (s_c1) c1_reg <= cmd[3:0];
      if (s_s2) s2_reg <= cmd[3:0];
      if (s_c2) c2_reg <= cmd[3:0];
      if (s_exec)
      begin
        // Duty only; bias, supply and drive form stay
        a_s1_reg     <= s1_reg;
        a_c1_reg     <= c1_reg;
        a_s2_reg     <= core.full ? 4'h0 : s2_reg;
        a_c2_reg     <= core.full ? 4'h0 : c2_reg;
        full_reg     <= core.full;
        duty_reg     <= core.duty;
        blk2_off_reg <= core.blk2_off;
      end
    end
  end

  // ==========================================================
  // n-line inverse and contrast registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nl_pend_reg  <= 6'h00;
      nl_reg       <= 6'h00;
      evr_pend_reg <= EVR_RESET;
      evr_reg      <= EVR_RESET;
    end
    else
    begin
      if (s_nl_hi)    nl_pend_reg[5:4]  <= cmd[1:0];
      if (s_nl_lo)    nl_pend_reg[3:0]  <= cmd[3:0];
      if (s_nl_exec)  nl_reg            <= nl_pend_reg;
      if (s_evr_hi)   evr_pend_reg[7:4] <= cmd[3:0];
      if (s_evr_lo)   evr_pend_reg[3:0] <= cmd[3:0];
      if (s_evr_exec) evr_reg           <= evr_pend_reg;
    end
  end

  // ==========================================================
  // Submodules
  lpd_display_mem u_mem
  (
    .pclk (pclk),
    .core (core.mem)
  );

  lpd_partial_calc u_calc
  (
    .core (core.calc)
  );

  // ==========================================================
  // Outputs straight from flip-flops
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign display_on      = disp_on_reg;
  assign pix_invert      = pix_inv_reg;
  assign pix_all_on      = pix_on_reg;
  assign power_save      = psave_reg;
  assign sub_table       = (table_reg == TBL_SUB);
  assign duty_ratio      = duty_reg;
  assign blk1_start      = a_s1_reg;
  assign blk1_count      = a_c1_reg;
  assign blk2_start      = a_s2_reg;
  assign blk2_count      = a_c2_reg;
  assign blk2_mem_offset = blk2_off_reg;
  assign nline_count     = nl_reg;
  assign evr_level       = evr_reg;

endmodule

// *** test/lpd_host_model.sv ***
module lpd_host_model
  import lpd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One APB transfer, bounded wait for pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    hung = 1'b1;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && hung; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        hung = 1'b0;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;   // Released lines do not keep old value
    pwdata <= ~d;
  endtask
endmodule

// *** test/lpd_top_sva.sv ***
module lpd_top_sva
  import lpd_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        display_on,
  input wire logic        pix_invert,
  input wire logic        pix_all_on,
  input wire logic        power_save,
  input wire logic        sub_table,
  input wire logic [6:0]  duty_ratio,
  input wire logic [3:0]  blk1_start,
  input wire logic [3:0]  blk1_count,
  input wire logic [3:0]  blk2_count,
  input wire logic [3:0]  blk2_mem_offset
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Decodes of taken command writes and of the full panel block setting
  wire logic take = psel && penable && !pready;
  wire logic cmd_wr = take && pwrite && (paddr == ADDR_CMD);
  wire logic full_sel = (blk1_start == 4'h0) && (blk1_count == 4'hB);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Properties
  ready_pulse_a: assert property (take |=> pready ##1 !pready)
    else $error("pready not a one cycle answer");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  sub_enter_a: assert property (
    cmd_wr && !sub_table && pwdata[7:0] == OP_SUB_ENTER |=> sub_table)
    else $error("sub table not entered");
  sub_end_a: assert property (
    cmd_wr && sub_table && pwdata[7:0] == OP_SUB_END |=> !sub_table)
    else $error("sub table not left");
  duty_cause_a: assert property (
    $changed(duty_ratio) |-> $past(cmd_wr && sub_table && pwdata[7:0] == SUB_EXEC))
    else $error("duty changed without execute");
  duty_units_a: assert property (
    !full_sel |-> duty_ratio == {blk1_count + blk2_count, 3'h0})
    else $error("duty not eight per unit");
  full_panel_a: assert property (
    full_sel |-> duty_ratio == 7'h58 && blk2_count == 4'h0)
    else $error("full panel settings wrong");
  blk2_offset_a: assert property (blk2_mem_offset == (full_sel ? 4'h0 : blk1_count))
    else $error("block two offset wrong");
  all_on_wins_a: assert property (pix_all_on |-> !pix_invert)
    else $error("inverse shown with all on");
  power_save_a: assert property (power_save == (pix_all_on && !display_on))
    else $error("power save mismatch");
endmodule

bind lpd_top lpd_top_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .display_on, .pix_invert, .pix_all_on, .power_save, .sub_table,
  .duty_ratio, .blk1_start, .blk1_count, .blk2_count, .blk2_mem_offset);

// *** test/tb_top.sv ***
module tb_top
  import lpd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        display_on, pix_invert, pix_all_on, power_save, sub_table;
  logic [6:0]  duty_ratio;
  logic [3:0]  blk1_start, blk1_count, blk2_start, blk2_count, blk2_mem_offset;
  logic [5:0]  nline_count;
  logic [7:0]  evr_level;
  logic [31:0] rd;
  logic        e;
  int          err_count, n_checks, i;

  // ==========================================================
  // Design, host and clock
  lpd_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .display_on, .pix_invert, .pix_all_on, .power_save, .sub_table,
    .duty_ratio, .blk1_start, .blk1_count, .blk2_start, .blk2_count, .blk2_mem_offset,
    .nline_count, .evr_level);
  lpd_host_model host_u (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ==========================================================
  // Access and compare tasks
  task automatic complete_run();
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic h;
    host_u.xfer(wr, a, d, rd, e, h);
    if (h)
    begin
      err_count++;
      $display("CHECK FAILED pready expected 1 seen 0");
      complete_run();
    end
  endtask

  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic xe);
    acc(1'b0, a, 32'h0);
    chk("prdata", exp, rd);
    chk("pslverr", 32'(xe), 32'(e));
  endtask

  // Full partial display sequence inside the sub table
  task automatic part(input logic [15:0] blk);
    int k;
    wrt(ADDR_CMD, OP_SUB_ENTER);
    chk("sub_table", 32'h1, 32'(sub_table));
    for (k = 0; k < 4; k++)
    begin
      wrt(ADDR_CMD, {k[3:0], blk[15 - 4 * k -: 4]});
    end
    wrt(ADDR_CMD, SUB_EXEC);
    wrt(ADDR_CMD, OP_SUB_END);
    chk("sub_table", 32'h0, 32'(sub_table));
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_DUTY, 32'h58, 1'b0);
    rdc(ADDR_BLOCKS, 32'hB0, 1'b0);
    rdc(8'h1C, 32'h0, 1'b1);
    rdc(ADDR_STATUS, 32'h20, 1'b0);
    wrt(ADDR_CMD, 8'h40);
    wrt(ADDR_CMD, 8'hC0);
    wrt(ADDR_CMD, 8'h10);
    wrt(ADDR_CMD, 8'h00);
    for (i = 1; i < 5; i++)
      wrt(ADDR_DATA, 8'(8'h11 * i));
    wrt(ADDR_CMD, 8'hAF);
    wrt(ADDR_CMD, 8'hA7);
    chk("pix_invert", 32'h1, 32'(pix_invert));
    wrt(ADDR_CMD, 8'hA5);
    chk("pix_all_on", 32'h1, 32'(pix_all_on));
    chk("pix_invert", 32'h0, 32'(pix_invert));
    wrt(ADDR_CMD, 8'hAE);
    chk("power_save", 32'h1, 32'(power_save));
    wrt(ADDR_CMD, 8'hA4);
    chk("power_save", 32'h0, 32'(power_save));
    wrt(ADDR_CMD, 8'hA6);
    wrt(ADDR_CMD, 8'h10);
    wrt(ADDR_CMD, 8'h00);
    acc(1'b0, ADDR_DATA, 32'h0);
    for (i = 1; i < 5; i++)
    begin
      if (i == 3)
      begin
        wrt(ADDR_CTRL, 8'h01);
        rdc(ADDR_DATA, 32'h0, 1'b1);
        wrt(ADDR_CTRL, 8'h00);
      end
      rdc(ADDR_DATA, 32'(8'h11 * i), 1'b0);
    end
    part(16'h0245);
    rdc(ADDR_DUTY, 32'h38, 1'b0);
    rdc(ADDR_BLOCKS, 32'h5420, 1'b0);
    chk("blk2_mem_offset", 32'h2, 32'(blk2_mem_offset));
    rdc(ADDR_DRIVE, 32'hFF, 1'b0);
    part(16'h3400);
    rdc(ADDR_DUTY, 32'h20, 1'b0);
    part(16'h0B32);
    rdc(ADDR_DUTY, 32'h58, 1'b0);
    rdc(ADDR_BLOCKS, 32'hB0, 1'b0);
    chk("blk2_mem_offset", 32'h0, 32'(blk2_mem_offset));
    // Sub mode n-line and contrast setup, kept across a partial execute
    wrt(ADDR_CMD, OP_SUB_ENTER);
    wrt(ADDR_CMD, 8'h52);
    wrt(ADDR_CMD, 8'h6A);
    wrt(ADDR_CMD, SUB_NL_EXEC);
    wrt(ADDR_CMD, 8'h83);
    wrt(ADDR_CMD, 8'h9C);
    wrt(ADDR_CMD, SUB_EVR_EXEC);
    wrt(ADDR_CMD, OP_SUB_END);
    chk("nline_count", 32'h2A, 32'(nline_count));
    chk("evr_level", 32'h3C, 32'(evr_level));
    part(16'h0245);
    rdc(ADDR_DRIVE, 32'h2A3C, 1'b0);
    chk("blocks", 32'h5420, {16'h0, blk2_count, blk2_start, blk1_count, blk1_start});
    // Mid-run reset while in sub mode with partial duty applied
    wrt(ADDR_CMD, 8'hAF);
    chk("display_on", 32'h1, 32'(display_on));
    wrt(ADDR_CMD, OP_SUB_ENTER);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("display_on", 32'h0, 32'(display_on));
    chk("sub_table", 32'h0, 32'(sub_table));
    chk("duty_ratio", 32'h58, 32'(duty_ratio));
    chk("evr_level", 32'hFF, 32'(evr_level));
    rdc(ADDR_BLOCKS, 32'hB0, 1'b0);
    complete_run();
  end
endmodule
